/* File: tsi_switch_top.v */
// top control of the 32 x 32 stream time slot interchange switch
`timescale 1ns/1ps
`include "tsi_consts.vh"

module tsi_switch_top (
  input  wire                aclk,
  input  wire                aresetn,
  input  wire                ser_clk,
  input  wire                frame_sync_in,
  input  wire                frame_measure_in,
  input  wire [31:0]         serial_in_streams,
  input  wire                output_drive_master_enable,
  output wire [31:0]         serial_out_streams,
  output reg  [31:0]         serial_out_oe,
  input  wire                tck,
  input  wire                tms,
  input  wire                tdi,
  input  wire                test_reset_n,
  output reg                 tdo,
  output reg                 tdo_oe,
  input  wire [`ADDR_W-1:0]  awaddr,
  input  wire                awvalid,
  output reg                 awready,
  input  wire [31:0]         wdata,
  input  wire [3:0]          wstrb,
  input  wire                wvalid,
  output reg                 wready,
  output reg  [1:0]          bresp,
  output reg                 bvalid,
  input  wire                bready,
  input  wire [`ADDR_W-1:0]  araddr,
  input  wire                arvalid,
  output reg                 arready,
  output reg  [31:0]         rdata,
  output reg  [1:0]          rresp,
  output reg                 rvalid,
  input  wire                rready
);
  localparam [15:0] S_TLR = 16'h0001, S_RTI = 16'h0002, S_SDS = 16'h0004, S_CDR = 16'h0008;
  localparam [15:0] S_SHD = 16'h0010, S_E1D = 16'h0020, S_PDR = 16'h0040, S_E2D = 16'h0080;
  localparam [15:0] S_UDR = 16'h0100, S_SIS = 16'h0200, S_CIR = 16'h0400, S_SHI = 16'h0800;
  localparam [15:0] S_E1I = 16'h1000, S_PIR = 16'h2000, S_E2I = 16'h4000, S_UIR = 16'h8000;

  reg  [255:0] dmem [0:63];
  reg  [15:0]  cmem [0:1023];
  reg  [3:0]   offs_q [0:31];
  reg          sclk_q, fsl_q, fel_q, fseen_q, fpar_q, fmt_q, fmtv_q;
  reg  [3:0]   run_q;
  reg  [9:0]   pos_q, meas_q;
  reg          measv_q, measd_q, osb_q;
  reg          wr_pend_q, wr_bank_q;
  reg  [4:0]   wr_ch_q, nch_q, seq_s_q, s1s_q;
  reg          seq_run_q, s1v_q;
  reg  [15:0]  ent_q;
  reg  [255:0] nxt_byte_q, out_sr_q;
  reg  [31:0]  nxt_oe_q, nxt_lb_q, cur_oe_q, cur_lb_q;
  reg          clr_busy_q;
  reg  [9:0]   clr_q;
  reg          aw_got_q, w_got_q;
  reg  [`ADDR_W-1:0] aw_q;
  reg  [31:0]  w_q;
  reg  [3:0]   ws_q;
  reg          sk_v_q;
  reg  [31:0]  sk_d_q;
  reg  [1:0]   sk_r_q;
  reg          tck_q;
  reg  [15:0]  tap_q, tap_d;
  reg  [1:0]   ir_sr_q;
  reg          byp_q;
  reg  [31:0]  rmux;
  reg  [1:0]   rmux_resp;
  wire [255:0] in_bytes;
  integer      i, j;

  // ==========================================================
  // serial timing
  wire e_rise   = ser_clk & ~sclk_q;
  wire e_fall   = ~ser_clk & sclk_q;
  wire e_any    = e_rise | e_fall;
  wire bnd_edge = fmt_q ? e_rise : e_fall;
  wire fs_act   = fmt_q ? fsl_q : ~fsl_q;
  wire fstart   = bnd_edge & fs_act & ~fseen_q;
  wire [9:0] npos = fstart ? 10'h000 : pos_q + 10'h001;
  wire bound    = e_any & (npos[1:0] == 2'h0);
  // edge three of four lands three quarters into the bit
  wire samp     = e_any & (npos[1:0] == 2'h3);
  wire ch_start = bound & (npos[4:2] == 3'h0);
  wire ch_end   = samp & (npos[4:2] == 3'h7);

  always @(posedge aclk) begin
    if (!aresetn) begin
      sclk_q <= 1'b0; fsl_q <= 1'b1; fel_q <= 1'b1; fseen_q <= 1'b0; fpar_q <= 1'b0;
      fmt_q <= 1'b0; fmtv_q <= 1'b0; run_q <= 4'h0; pos_q <= 10'h000;
      meas_q <= 10'h000; measv_q <= 1'b0; measd_q <= 1'b0;
      wr_pend_q <= 1'b0; wr_bank_q <= 1'b0; wr_ch_q <= 5'h00;
    end else begin
      sclk_q    <= ser_clk;
      wr_pend_q <= ch_end;
      if (ch_end) begin
        wr_ch_q   <= npos[9:5];
        wr_bank_q <= fpar_q;
      end
      if (e_any) begin
        pos_q <= npos;
        fsl_q <= frame_sync_in;
        fel_q <= frame_measure_in;
        if (frame_sync_in != fsl_q) begin
          run_q <= 4'h0;
          // the short level is the pulse; its polarity names the format
          if (run_q <= `RUN_SHORT) begin
            fmt_q  <= fsl_q;
            fmtv_q <= 1'b1;
          end
        end else if (run_q != 4'hF)
          run_q <= run_q + 4'h1;
        if (fstart) begin
          fseen_q <= 1'b1;
          fpar_q  <= ~fpar_q;
          measd_q <= 1'b0;
        end else if (!fs_act)
          fseen_q <= 1'b0;
        if (!measd_q && !fstart && fel_q && !frame_measure_in) begin
          meas_q  <= npos;
          measv_q <= 1'b1;
          measd_q <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // input lanes and data memory
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : lane
      tsi_in_lane u_lane (
        .aclk    (aclk),
        .aresetn (aresetn),
        .edge_en (e_any),
        .samp_en (samp),
        .din     (cur_lb_q[g] ? out_sr_q[8*g+7] : serial_in_streams[g]),
        .offset  (offs_q[g]),
        .byte_q  (in_bytes[8*g+7:8*g])
      );
    end
  endgenerate

  always @(posedge aclk) begin
    if (wr_pend_q)
      dmem[{wr_bank_q, wr_ch_q}] <= in_bytes;
  end

  // ==========================================================
  // output sequencer: looks up all 32 streams of the next channel
  wire        out_par = (nch_q == 5'h00) ? ~fpar_q : fpar_q;
  wire        src_new = ({1'b0, ent_q[4:0]} + 6'h01) < {1'b0, nch_q};
  wire        rd_bank = ent_q[`CM_CONST] ? ~out_par : (src_new ? out_par : ~out_par);
  wire [255:0] dword  = dmem[{rd_bank, ent_q[4:0]}];
  wire [7:0]  dsel    = dword[{ent_q[9:5], 3'h0} +: 8];
  wire [7:0]  obyte   = ent_q[`CM_PROC] ? ent_q[7:0] : dsel;

  always @(posedge aclk) begin
    if (!aresetn) begin
      seq_run_q <= 1'b0; seq_s_q <= 5'h00; s1v_q <= 1'b0; s1s_q <= 5'h00;
      nch_q <= 5'h00; ent_q <= 16'h0000;
      nxt_byte_q <= 256'h0; nxt_oe_q <= 32'h0; nxt_lb_q <= 32'h0;
      out_sr_q <= 256'h0; cur_oe_q <= 32'h0; cur_lb_q <= 32'h0; serial_out_oe <= 32'h0;
    end else begin
      if (ch_start) begin
        seq_run_q <= 1'b1;
        seq_s_q   <= 5'h00;
        nch_q     <= npos[9:5] + 5'h01;
      end else if (seq_run_q) begin
        seq_s_q <= seq_s_q + 5'h01;
        if (seq_s_q == 5'h1F)
          seq_run_q <= 1'b0;
      end
      s1v_q <= seq_run_q & ~ch_start;
      s1s_q <= seq_s_q;
      ent_q <= cmem[{seq_s_q, nch_q}];
      if (s1v_q) begin
        nxt_byte_q[{s1s_q, 3'h0} +: 8] <= obyte;
        nxt_oe_q[s1s_q] <= ent_q[`CM_OE];
        nxt_lb_q[s1s_q] <= ent_q[`CM_LOOP];
      end
      if (bound) begin
        if (ch_start) begin
          out_sr_q <= nxt_byte_q;
          cur_oe_q <= nxt_oe_q;
          cur_lb_q <= nxt_lb_q;
        end else begin
          for (i = 0; i < 32; i = i + 1)
            out_sr_q[8*i +: 8] <= {out_sr_q[8*i +: 7], 1'b0};
        end
      end
      // master enables override every channel enable
      serial_out_oe <= cur_oe_q & {32{output_drive_master_enable & osb_q}};
    end
  end

  generate
    for (g = 0; g < 32; g = g + 1) begin : txo
      assign serial_out_streams[g] = out_sr_q[8*g+7];
    end
  endgenerate

  // ==========================================================
  // register bus: write side
  wire aw_take  = awvalid & awready;
  wire w_take   = wvalid & wready;
  wire do_wr    = aw_got_q & w_got_q & ~bvalid & ~clr_busy_q;
  wire aw_got_n = do_wr ? 1'b0 : (aw_got_q | aw_take);
  wire w_got_n  = do_wr ? 1'b0 : (w_got_q | w_take);
  wire is_ctrl  = (aw_q == `REG_CTRL);
  wire is_stat  = (aw_q == `REG_STATUS);
  wire is_offs  = (aw_q[12:7] == `REG_OFFS_HI);
  wire is_cm    = aw_q[`REG_CMEM_BIT];
  wire [15:0] cm_old = cmem[aw_q[11:2]];
  wire [15:0] cm_new = {ws_q[1] ? w_q[15:8] : cm_old[15:8], ws_q[0] ? w_q[7:0] : cm_old[7:0]};

  // memory is swept to zero after reset so no channel drives stale contents
  always @(posedge aclk) begin
    if (clr_busy_q)
      cmem[clr_q] <= 16'h0000;
    else if (do_wr && is_cm)
      cmem[aw_q[11:2]] <= cm_new;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0; wready <= 1'b0; bvalid <= 1'b0; bresp <= `RESP_OKAY;
      aw_got_q <= 1'b0; w_got_q <= 1'b0; aw_q <= {`ADDR_W{1'b0}};
      w_q <= 32'h0; ws_q <= 4'h0; osb_q <= `CTRL_RST;
      clr_busy_q <= 1'b1; clr_q <= 10'h000;
      for (j = 0; j < 32; j = j + 1)
        offs_q[j] <= `OFFS_RST;
    end else begin
      if (clr_busy_q) begin
        clr_q <= clr_q + 10'h001;
        if (clr_q == 10'h3FF)
          clr_busy_q <= 1'b0;
      end
      aw_got_q <= aw_got_n;
      w_got_q  <= w_got_n;
      awready  <= ~aw_got_n;
      wready   <= ~w_got_n;
      if (aw_take)
        aw_q <= awaddr;
      if (w_take) begin
        w_q  <= wdata;
        ws_q <= wstrb;
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp  <= (is_ctrl | is_stat | is_offs | is_cm) ? `RESP_OKAY : `RESP_SLVERR;
        if (is_ctrl && ws_q[0])
          osb_q <= w_q[`CTRL_OSB];
        if (is_offs && ws_q[0])
          offs_q[aw_q[6:2]] <= (w_q[3:0] > `OFFS_MAX) ? `OFFS_MAX : w_q[3:0];
      end else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // register bus: read side with two-entry buffer
  always @* begin
    rmux      = 32'h0;
    rmux_resp = `RESP_OKAY;
    if (araddr[`REG_CMEM_BIT])
      rmux = {16'h0000, cmem[araddr[11:2]]};
    else if (araddr == `REG_CTRL)
      rmux = {31'h0, osb_q};
    else if (araddr == `REG_STATUS)
      rmux = {6'h00, meas_q, 13'h0000, measv_q, fmtv_q, fmt_q};
    else if (araddr[12:7] == `REG_OFFS_HI)
      rmux = {28'h0, offs_q[araddr[6:2]]};
    else
      rmux_resp = `RESP_SLVERR;
  end

  wire ar_take = arvalid & arready;
  wire pop     = rvalid & rready;
  wire load_sk = ar_take & ((rvalid & ~pop) | (pop & sk_v_q));
  wire sk_v_n  = pop ? (sk_v_q & ar_take) : (sk_v_q | load_sk);

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0; rdata <= 32'h0; rresp <= `RESP_OKAY; arready <= 1'b0;
      sk_v_q <= 1'b0; sk_d_q <= 32'h0; sk_r_q <= `RESP_OKAY;
    end else begin
      // a stalled reader fills the skid entry, then address acceptance stops
      arready <= ~sk_v_n;
      sk_v_q  <= sk_v_n;
      rvalid  <= pop ? (sk_v_q | ar_take) : (rvalid | ar_take);
      if (pop && sk_v_q) begin
        rdata <= sk_d_q;
        rresp <= sk_r_q;
      end else if (ar_take && !load_sk) begin
        rdata <= rmux;
        rresp <= rmux_resp;
      end
      if (load_sk) begin
        sk_d_q <= rmux;
        sk_r_q <= rmux_resp;
      end
    end
  end

  // ==========================================================
  // test access port (bypass only, no scan cells)
  wire t_rise = tck & ~tck_q;
  wire t_fall = ~tck & tck_q;

  always @* begin
    case (tap_q)
      S_TLR:   tap_d = tms ? S_TLR : S_RTI;
      S_RTI:   tap_d = tms ? S_SDS : S_RTI;
      S_SDS:   tap_d = tms ? S_SIS : S_CDR;
      S_CDR:   tap_d = tms ? S_E1D : S_SHD;
      S_SHD:   tap_d = tms ? S_E1D : S_SHD;
      S_E1D:   tap_d = tms ? S_UDR : S_PDR;
      S_PDR:   tap_d = tms ? S_E2D : S_PDR;
      S_E2D:   tap_d = tms ? S_UDR : S_SHD;
      S_UDR:   tap_d = tms ? S_SDS : S_RTI;
      S_SIS:   tap_d = tms ? S_TLR : S_CIR;
      S_CIR:   tap_d = tms ? S_E1I : S_SHI;
      S_SHI:   tap_d = tms ? S_E1I : S_SHI;
      S_E1I:   tap_d = tms ? S_UIR : S_PIR;
      S_PIR:   tap_d = tms ? S_E2I : S_PIR;
      S_E2I:   tap_d = tms ? S_UIR : S_SHI;
      S_UIR:   tap_d = tms ? S_SDS : S_RTI;
      default: tap_d = S_TLR;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn)
      tck_q <= 1'b0;
    else
      tck_q <= tck;
  end

  // test reset acts without any clock edge
  always @(posedge aclk or negedge test_reset_n) begin
    if (!test_reset_n) begin
      tap_q   <= S_TLR;
      ir_sr_q <= 2'h0;
      byp_q   <= 1'b0;
      tdo     <= 1'b0;
      tdo_oe  <= 1'b0;
    end else begin
      if (t_rise) begin
        tap_q <= tap_d;
        if (tap_q == S_CIR)
          ir_sr_q <= `IR_CAPTURE;
        else if (tap_q == S_SHI)
          ir_sr_q <= {tdi, ir_sr_q[1]};
        if (tap_q == S_CDR)
          byp_q <= 1'b0;
        else if (tap_q == S_SHD)
          byp_q <= tdi;
      end
      if (t_fall) begin
        tdo    <= (tap_q == S_SHI) ? ir_sr_q[0] : byp_q;
        tdo_oe <= (tap_q == S_SHI) | (tap_q == S_SHD);
      end
    end
  end
endmodule

/* File: tsi_consts.vh */
// constants shared by the slot switch control and its input lanes
`ifndef TSI_CONSTS_VH
`define TSI_CONSTS_VH

// ==========================================================
// register map (byte addresses)
`define ADDR_W         13
`define REG_CTRL       13'h0000
`define REG_STATUS     13'h0004
`define REG_OFFS_HI    6'h01
`define REG_CMEM_BIT   12

// ==========================================================
// field positions
`define CTRL_OSB       0
`define ST_FMT         0
`define ST_FMT_VALID   1
`define ST_MEAS_VALID  2
`define ST_MEAS_LSB    16
`define CM_PROC        12
`define CM_CONST       13
`define CM_OE          14
`define CM_LOOP        15

// ==========================================================
// reset values and limits
`define CTRL_RST       1'h0
`define OFFS_RST       4'h0
`define OFFS_MAX       4'h9
`define RUN_SHORT      4'h4
`define IR_CAPTURE     2'h1
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

// ==========================================================
// timing
`define CLK_PERIOD_NS  50
`define SER_CLK_KHZ    4096
`define DATA_RATE_KBPS 2048
`define FRAME_US       125
`define EDGES_PER_BIT  4
`define RESET_MIN_NS   100
`define RESET_MIN_CYC  ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: tsi_in_lane.v */
// one serial input lane: half-clock offset delay line and byte deserialiser
`timescale 1ns/1ps
`include "tsi_consts.vh"

module tsi_in_lane (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       edge_en,
  input  wire       samp_en,
  input  wire       din,
  input  wire [3:0] offset,
  output reg  [7:0] byte_q
);
  reg  [8:0] dl_q;
  wire [3:0] tap = offset - 4'h1;
  // offset is clamped to nine on write, so the tap never leaves the line
  wire       dly = (offset == 4'h0) ? din : dl_q[tap];

  always @(posedge aclk) begin
    if (!aresetn) begin
      dl_q   <= 9'h000;
      byte_q <= 8'h00;
    end else begin
      if (edge_en)
        dl_q <= {dl_q[7:0], din};
      if (samp_en)
        byte_q <= {byte_q[6:0], dly};
    end
  end
endmodule

/* File: tsi_switch_asserts.sv */
// concurrent checks on the slot switch top ports
`timescale 1ns/1ps
// ==========================================
// checker
module tsi_switch_asserts (
  input wire        aclk,
  input wire        aresetn,
  input wire        output_drive_master_enable,
  input wire [31:0] serial_out_oe,
  input wire        tck,
  input wire        test_reset_n,
  input wire        tdo,
  input wire        tdo_oe,
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire [1:0]  bresp,
  input wire        bvalid,
  input wire        bready,
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire [1:0]  rresp,
  input wire        rvalid,
  input wire        rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  // sweep after reset can hold the answer about 1025 cycles, too long for a delay range
  reg        wr_wait_q;
  reg [10:0] wr_cnt_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_wait_q <= 1'b0;
      wr_cnt_q  <= 11'h000;
    end else if (bvalid) begin
      wr_wait_q <= 1'b0;
      wr_cnt_q  <= 11'h000;
    end else if (wr_wait_q || (awvalid && awready && wvalid && wready)) begin
      wr_wait_q <= 1'b1;
      wr_cnt_q  <= wr_cnt_q + 11'h001;
    end
  end
  AST_WR_RESP: assert property (wr_wait_q |-> wr_cnt_q < 11'h44C)
    else $error("write got no response");
  AST_WR_REFUSE: assert property (wr_taken |=> !awready && !wready)
    else $error("second write accepted while one is held");
  AST_RD_RESP: assert property (arvalid && arready && !rvalid |=> rvalid)
    else $error("read got no data");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped early");
  AST_RST_CLEAR: assert property ($rose(aresetn) |-> serial_out_oe == 32'h0 && !bvalid)
    else $error("outputs not cleared by reset");
  AST_MASTER_OFF: assert property (!output_drive_master_enable |=> serial_out_oe == 32'h0)
    else $error("serial output driven while master enable low");
  AST_OE_CAUSE: assert property ($rose(|serial_out_oe) |-> $past(output_drive_master_enable))
    else $error("serial drive began without master enable");
  AST_TRST: assert property (!test_reset_n |-> !tdo_oe && !tdo)
    else $error("test reset did not clear test output");
  AST_TDO_EDGE: assert property (test_reset_n && ($changed(tdo) || $changed(tdo_oe)) |-> !tck)
    else $error("test output moved while test clock high");
endmodule

bind tsi_switch_top tsi_switch_asserts i_tsi_switch_asserts (
  .aclk(aclk), .aresetn(aresetn), .output_drive_master_enable(output_drive_master_enable),
  .serial_out_oe(serial_out_oe), .tck(tck), .test_reset_n(test_reset_n), .tdo(tdo),
  .tdo_oe(tdo_oe), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
);

/* File: tdm_far_end.sv */
// behavioural far-end stream device: clock, frame pulse, data, sampler
`timescale 1ns/1ps
// ==========================================
// far end
module tdm_far_end (
  input  wire        fmt_b,
  input  wire        clr,
  input  wire [31:0] in_pattern,
  input  wire [31:0] tx,
  input  wire [31:0] tx_oe,
  output reg         ser_clk,
  output reg         frame_sync_in,
  output reg         frame_measure_in,
  output wire [31:0] serial_in_streams,
  output reg  [31:0] seen1,
  output reg  [31:0] seen0,
  output reg  [31:0] seen_oe
);
  integer e;
  assign serial_in_streams = in_pattern;
  initial begin
    ser_clk = 1'b1;
    e = 1000;
    frame_sync_in = 1'b1;
    frame_measure_in = 1'b1;
    // 1 ps skew keeps edges off the system clock grid
    #0.001;
    forever begin
      #122.07 ser_clk = ~ser_clk;
      if (e != 1023 || ser_clk == fmt_b)
        e = (e + 1) % 1024;
      frame_sync_in = (e == 1023 || e == 0) ? fmt_b : ~fmt_b;
      frame_measure_in = !(e >= 40 && e < 600);
      if (clr) begin
        seen1 = 32'h0;
        seen0 = 32'h0;
        seen_oe = 32'h0;
      end else if (e % 4 == 3) begin
        seen1 = seen1 | (tx & tx_oe);
        seen0 = seen0 | (~tx & tx_oe);
        seen_oe = seen_oe | tx_oe;
      end
    end
  end
endmodule

/* File: tb_top.sv */
// self-checking bench for the slot switch top
`timescale 1ns/1ps
`include "tsi_consts.vh"
// ==========================================
// bench top
module tb_top;
  reg         aclk, aresetn, master_en, tck, tms, tdi, test_reset_n, fmt_b, clr;
  reg         awvalid, wvalid, bready, arvalid, rready;
  reg  [12:0] awaddr, araddr;
  reg  [31:0] wdata, in_pattern, d;
  wire        ser_clk, fsync, fmeas, tdo, tdo_oe, awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] tx, tx_oe, rx, rdata, seen1, seen0, seen_oe;
  integer     fail_count, checks_done, s, c;

  tsi_switch_top i_tsi_switch_top (
    .aclk(aclk), .aresetn(aresetn), .ser_clk(ser_clk), .frame_sync_in(fsync),
    .frame_measure_in(fmeas), .serial_in_streams(rx), .output_drive_master_enable(master_en),
    .serial_out_streams(tx), .serial_out_oe(tx_oe), .tck(tck), .tms(tms), .tdi(tdi),
    .test_reset_n(test_reset_n), .tdo(tdo), .tdo_oe(tdo_oe), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready)
  );
  tdm_far_end i_tdm_far_end (
    .fmt_b(fmt_b), .clr(clr), .in_pattern(in_pattern), .tx(tx), .tx_oe(tx_oe),
    .ser_clk(ser_clk), .frame_sync_in(fsync), .frame_measure_in(fmeas),
    .serial_in_streams(rx), .seen1(seen1), .seen0(seen0), .seen_oe(seen_oe)
  );

  // ==========================================
  // tasks
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // ready raised only after valid is seen, so hold checks get exercised
  task wr(input [12:0] a, input [31:0] dv, input [1:0] r);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= dv;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (!awvalid && !wvalid && bvalid) bready <= 1'b1;
      end while (!(bready && bvalid));
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, r});
    end
  endtask
  task rd(input [12:0] a, input [31:0] m, input [31:0] e, input [1:0] r);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (!arvalid && rvalid) rready <= 1'b1;
      end while (!(rready && rvalid));
      rready <= 1'b0;
      chk(rdata & m, e);
      chk({30'h0, rresp}, {30'h0, r});
    end
  endtask
  task tap(input m);
    begin
      @(posedge aclk);
      tms <= m;
      repeat (4) @(posedge aclk);
      tck <= 1'b1;
      repeat (4) @(posedge aclk);
      tck <= 1'b0;
      repeat (6) @(posedge aclk);
    end
  endtask
  task sample;
    begin
      clr <= 1'b1;
      repeat (10) @(posedge aclk);
      clr <= 1'b0;
      repeat (2600) @(posedge aclk);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // ==========================================
  // clock, watchdog
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    repeat (60000) @(posedge aclk);
    fail_count = fail_count + 1;
    end_of_test;
  end

  // ==========================================
  // tests
  initial begin
    {aresetn, master_en, tck, fmt_b, clr, test_reset_n} = 6'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {tms, tdi} = 2'h3;
    awaddr = 13'h0;
    araddr = 13'h0;
    wdata = 32'h0;
    in_pattern = 32'h1;
    fail_count = 0;
    checks_done = 0;
    repeat (12) @(posedge aclk);
    chk(tx_oe, 32'h0);
    chk(tx, 32'h0);
    chk({31'h0, tdo_oe}, 32'h0);
    aresetn <= 1'b1;
    test_reset_n <= 1'b1;
    master_en <= 1'b1;
    rd(`REG_CTRL, 32'hFFFFFFFF, 32'h0, `RESP_OKAY);
    rd(13'h0008, 32'hFFFFFFFF, 32'h0, `RESP_SLVERR);
    wr(13'h0008, 32'h1, `RESP_SLVERR);
    wr(13'h0080, 32'hF, `RESP_OKAY);
    rd(13'h0080, 32'hF, {28'h0, `OFFS_MAX}, `RESP_OKAY);
    for (s = 2; s < 8; s = s + 1)
      for (c = 0; c < 32; c = c + 1) begin
        case (s)
          2: d = 32'h4000 + 31 - c;
          3: d = 32'h70FF;
          4: d = 32'h6020 + c;
          5: d = 32'h0000 + c;
          6: d = 32'hD0FF;
          default: d = 32'h40C0 + c;
        endcase
        wr({1'b1, s[4:0], c[4:0], 2'b00}, d, `RESP_OKAY);
      end
    repeat (3) @(posedge aclk);
    chk(tx_oe, 32'h0);
    wr(`REG_CTRL, 32'h1, `RESP_OKAY);
    repeat (5000) @(posedge aclk);
    sample;
    chk(seen1 & 32'hDC, 32'hCC);
    chk(seen0 & 32'hDC, 32'h10);
    chk(seen_oe & 32'h20, 32'h0);
    rd(`REG_STATUS, 32'h03FF0007, 32'h00280006, `RESP_OKAY);
    fmt_b <= 1'b1;
    repeat (7500) @(posedge aclk);
    rd(`REG_STATUS, 32'h03FF0007, 32'h00280007, `RESP_OKAY);
    sample;
    chk(seen1 & 32'hDC, 32'hCC);
    chk(tx_oe & 32'hFC, 32'hDC);
    master_en <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(tx_oe, 32'h0);
    master_en <= 1'b1;
    wr(`REG_CTRL, 32'h0, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(tx_oe, 32'h0);
    tap(1'b0);
    tap(1'b1);
    tap(1'b0);
    tap(1'b0);
    chk({30'h0, tdo_oe, tdo}, 32'h2);
    tap(1'b0);
    chk({30'h0, tdo_oe, tdo}, 32'h3);
    tap(1'b1);
    chk({31'h0, tdo_oe}, 32'h0);
    tap(1'b0);
    tap(1'b1);
    tap(1'b0);
    chk({31'h0, tdo_oe}, 32'h1);
    test_reset_n <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({31'h0, tdo_oe}, 32'h0);
    test_reset_n <= 1'b1;
    wr(`REG_CTRL, 32'h1, `RESP_OKAY);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(tx_oe, 32'h0);
    aresetn <= 1'b1;
    rd(`REG_CTRL, 32'hFFFFFFFF, 32'h0, `RESP_OKAY);
    end_of_test;
  end
endmodule
